// file: core/task_file_port.sv
// Notes on behaviour
// R01: Chip select 0 alone maps the three address lines to eight command registers.
// R02: Chip select 1 alone: alternate status and control at 6, readback at 7.
// R03: Alternate status reads show status but leave a pending interrupt alone.
// R04: Writing the command register launches the command at once.
// R05: Host loads all parameter registers before writing the command.
// R06: Cylinder upper holds high cylinder or address 16-23; updated at command end.
// R07: Cylinder lower holds low cylinder or address 8-15; updated at command end.
// R08: Data port moves buffer blocks, format and identify data between host and core.
// R09: Data transfers are 16 bits, ECC bytes 8 bits, programmed I/O only.
// R10: Data port holds valid data only while the transfer request flag is set.
// R11: Soft reset bit one holds the device in reset; clearing it releases.
// R12: Host holds soft reset set at least 5 us before clearing it.
// R13: Interrupts reach the host only when unmasked and this unit is selected.
// R14: Readback bit 7 is never driven.
// R15: Write active bit reads zero while a disk write is in progress.
// R16: Inverted head field returns complement of selected head, LSB lowest.
// R17: Two lowest readback bits are active-low selects for unit 1 and unit 0.
// R18: Linear bit chooses CHS when zero and LBA when one.
// R19: Unit select bit chooses unit 0 when zero, unit 1 when one.
// R20: Low four unit/head bits hold head or address 24-27; updated at command end.
// R21: Unit/head bits 7 and 5 read one; control bit 3 written one, bit 0 zero.
// R22: Primary status read acknowledges and clears a pending interrupt.
// R23: Sector register holds address 0-7 and is updated at command end.
// R24: A sector count of zero means 256 sectors.
`timescale 1ns/1ps
`default_nettype none

module data_buffer2 #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [1:0] vld_q;
  logic [WIDTH-1:0] slot_q [2];
  logic push;
  logic pop;
  logic room_q;
  assign in_ready = room_q;
  assign out_valid = vld_q[0];
  assign out_data = slot_q[0];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (!reset_n || flush) begin
      vld_q <= 2'b00;
      room_q <= 1'b1;
    end else begin
      room_q <= !(push && !pop ? vld_q[0] : !(pop && !push) && vld_q[1]);
      unique case ({push, pop})
        2'b10: vld_q <= {vld_q[0], 1'b1};
        2'b01: vld_q <= {1'b0, vld_q[1]};
        default: vld_q <= vld_q;
      endcase
    end
  end

  // Head slot always feeds the output so the consumer sees a stored word
  always_ff @(posedge clock) begin
    if (pop) begin
      slot_q[0] <= vld_q[1] ? slot_q[1] : in_data;
      slot_q[1] <= in_data;
    end else if (push) begin
      if (!vld_q[0]) begin
        slot_q[0] <= in_data;
      end else begin
        slot_q[1] <= in_data;
      end
    end
  end
endmodule

module task_file_port #(
  parameter logic UNIT_ID = 1'b0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic [2:0] da,
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic [15:0] dd_in,
  output logic [15:0] dd_out,
  output logic [15:0] dd_oe,
  output logic intrq,
  input wire logic [7:0] status_in,
  input wire logic [7:0] error_in,
  input wire logic intr_event,
  input wire logic write_active,
  input wire logic xfer_active,
  input wire logic xfer_to_host,
  input wire logic ecc_byte_mode,
  input wire logic end_valid,
  input wire task_file_pkg::end_update_t end_data,
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [15:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [15:0] wr_data,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output task_file_pkg::taskfile_t params,
  output logic core_reset
);

  function automatic task_file_pkg::reg_sel_t decode_sel(input logic c0_n, input logic c1_n,
                                                         input logic [2:0] a);
    decode_sel = task_file_pkg::SEL_NONE;
    if (!c0_n && c1_n) begin
      decode_sel = task_file_pkg::reg_sel_t'({1'b0, a}); // R01
    end else if (c0_n && !c1_n) begin
      if (a == task_file_pkg::DA_ALT) begin
        decode_sel = task_file_pkg::SEL_ALT; // R02
      end else if (a == task_file_pkg::DA_DRV_ADDR) begin
        decode_sel = task_file_pkg::SEL_DRV_ADDR; // R02
      end
    end
  endfunction

  task_file_pkg::pins_t pins;
  task_file_pkg::pins_t s1_q;
  task_file_pkg::pins_t s2_q;
  logic dior_prev_n_q;
  logic diow_prev_n_q;
  logic rd_start;
  logic rd_end;
  logic wr_end;
  task_file_pkg::reg_sel_t live_sel;
  task_file_pkg::reg_sel_t rd_sel_q;
  logic [7:0] ctl_q;
  logic [7:0] features_q;
  logic [7:0] count_q;
  logic [7:0] sector_q;
  logic [7:0] cyl_lo_q;
  logic [7:0] cyl_hi_q;
  logic [7:0] unit_head_q;
  logic pending_q;
  logic intrq_q;
  logic core_reset_q;
  logic cmd_valid_q;
  logic [7:0] cmd_code_q;
  task_file_pkg::taskfile_t params_q;
  logic [15:0] dd_out_q;
  logic [15:0] dd_oe_q;
  logic soft_reset;
  logic unit_selected;
  logic xfer_req;
  logic [7:0] status_view;
  logic [7:0] drv_addr_view;
  logic [15:0] rd_value;
  logic [15:0] rd_oe;
  logic host_out_valid;
  logic [15:0] host_out_data;
  logic host_pop;
  logic host_in_ready;
  logic host_push;

  assign pins = '{cs0_n: cs0_n, cs1_n: cs1_n, da: da, dior_n: dior_n, diow_n: diow_n, dd: dd_in};

  // Bus pins come from the host's timing; two stages before anything looks at them
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s1_q <= '{cs0_n: 1'b1, cs1_n: 1'b1, da: 3'h0, dior_n: 1'b1, diow_n: 1'b1, dd: 16'h0000};
      s2_q <= '{cs0_n: 1'b1, cs1_n: 1'b1, da: 3'h0, dior_n: 1'b1, diow_n: 1'b1, dd: 16'h0000};
      dior_prev_n_q <= 1'b1;
      diow_prev_n_q <= 1'b1;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      dior_prev_n_q <= s2_q.dior_n;
      diow_prev_n_q <= s2_q.diow_n;
    end
  end

  assign rd_start = !s2_q.dior_n && dior_prev_n_q;
  assign rd_end = s2_q.dior_n && !dior_prev_n_q;
  // Writes are taken as the strobe rises, when address and data have settled
  assign wr_end = s2_q.diow_n && !diow_prev_n_q;
  assign live_sel = decode_sel(s2_q.cs0_n, s2_q.cs1_n, s2_q.da);

  assign soft_reset = ctl_q[task_file_pkg::CTL_SOFT_RESET]; // R11
  assign unit_selected = unit_head_q[task_file_pkg::UH_UNIT] == UNIT_ID; // R19
  assign xfer_req = xfer_active && (xfer_to_host ? host_out_valid : host_in_ready);
  assign status_view = {status_in[7:4], xfer_req, status_in[2:0]};
  assign drv_addr_view = {1'b0, !write_active, ~unit_head_q[3:0], // R15 R16
                          !(unit_head_q[task_file_pkg::UH_UNIT] && !soft_reset), // R17
                          !(!unit_head_q[task_file_pkg::UH_UNIT] && !soft_reset)};
  assign host_pop = rd_end && rd_sel_q == task_file_pkg::SEL_DATA && xfer_active && xfer_to_host;
  assign host_push = wr_end && live_sel == task_file_pkg::SEL_DATA && xfer_active
                     && !xfer_to_host && !soft_reset;

  // Read buffer: core fills, host drains through the data port
  data_buffer2 #(.WIDTH(16)) to_host_buf (
    .clock(clock),
    .reset_n(reset_n),
    .flush(soft_reset),
    .in_valid(rd_valid),
    .in_ready(rd_ready),
    .in_data(rd_data),
    .out_valid(host_out_valid),
    .out_ready(host_pop),
    .out_data(host_out_data)
  );

  // Write buffer: host fills, a stalled core leaves it full and drops the request flag
  data_buffer2 #(.WIDTH(16)) from_host_buf (
    .clock(clock),
    .reset_n(reset_n),
    .flush(soft_reset),
    .in_valid(host_push),
    .in_ready(host_in_ready),
    .in_data(s2_q.dd),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_data)
  );

  always_comb begin
    rd_value = 16'h0000;
    rd_oe = task_file_pkg::OE_BYTE;
    unique case (live_sel)
      task_file_pkg::SEL_DATA: begin
        rd_value = xfer_req && xfer_to_host ? host_out_data : 16'h0000; // R10
        rd_oe = ecc_byte_mode ? task_file_pkg::OE_BYTE : task_file_pkg::OE_WORD; // R09 R08
      end
      task_file_pkg::SEL_FEATURES: rd_value = {8'h00, error_in};
      task_file_pkg::SEL_COUNT: rd_value = {8'h00, count_q};
      task_file_pkg::SEL_SECTOR: rd_value = {8'h00, sector_q};
      task_file_pkg::SEL_CYL_LO: rd_value = {8'h00, cyl_lo_q};
      task_file_pkg::SEL_CYL_HI: rd_value = {8'h00, cyl_hi_q};
      task_file_pkg::SEL_UNIT_HEAD: rd_value = {8'h00, unit_head_q}; // R21
      task_file_pkg::SEL_STATUS: rd_value = {8'h00, status_view};
      task_file_pkg::SEL_ALT: rd_value = {8'h00, status_view}; // R03
      task_file_pkg::SEL_DRV_ADDR: begin
        rd_value = {8'h00, drv_addr_view};
        rd_oe = task_file_pkg::OE_DRV_ADDR; // R14
      end
      default: rd_oe = task_file_pkg::OE_NONE; // R02
    endcase
  end

  // Read data is captured at the strobe's fall and held until it rises
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dd_out_q <= 16'h0000;
      dd_oe_q <= task_file_pkg::OE_NONE;
      rd_sel_q <= task_file_pkg::SEL_NONE;
    end else if (rd_start) begin
      dd_out_q <= rd_value;
      dd_oe_q <= rd_oe;
      rd_sel_q <= live_sel;
    end else if (rd_end || s2_q.dior_n) begin
      dd_oe_q <= task_file_pkg::OE_NONE;
      rd_sel_q <= task_file_pkg::SEL_NONE;
    end
  end

  // Port control is not touched by its own soft reset bit
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctl_q <= task_file_pkg::CTL_RESET;
      core_reset_q <= 1'b1;
    end else begin
      if (wr_end && live_sel == task_file_pkg::SEL_ALT) begin
        ctl_q <= {4'h0, 1'b1, s2_q.dd[2:1], 1'b0}; // R21
      end
      core_reset_q <= soft_reset; // R11
    end
  end

  // Command end updates first; a host write in the same cycle wins
  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset) begin
      features_q <= task_file_pkg::FEATURES_RESET;
      count_q <= task_file_pkg::COUNT_RESET;
      sector_q <= task_file_pkg::SECTOR_RESET;
      cyl_lo_q <= task_file_pkg::CYL_RESET;
      cyl_hi_q <= task_file_pkg::CYL_RESET;
      unit_head_q <= task_file_pkg::UH_FIXED;
    end else begin
      if (end_valid) begin
        count_q <= end_data.count;
        sector_q <= end_data.sector; // R23
        cyl_lo_q <= end_data.cyl_lo; // R07
        cyl_hi_q <= end_data.cyl_hi; // R06
        unit_head_q[3:0] <= end_data.head; // R20
      end
      if (wr_end) begin
        unique case (live_sel)
          task_file_pkg::SEL_FEATURES: features_q <= s2_q.dd[7:0];
          task_file_pkg::SEL_COUNT: count_q <= s2_q.dd[7:0];
          task_file_pkg::SEL_SECTOR: sector_q <= s2_q.dd[7:0];
          task_file_pkg::SEL_CYL_LO: cyl_lo_q <= s2_q.dd[7:0];
          task_file_pkg::SEL_CYL_HI: cyl_hi_q <= s2_q.dd[7:0];
          task_file_pkg::SEL_UNIT_HEAD: unit_head_q <= s2_q.dd[7:0] | task_file_pkg::UH_FIXED;
          default: begin
          end
        endcase
      end
    end
  end

  // Parameters are frozen at launch, so the host must have loaded them before
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cmd_valid_q <= 1'b0;
      cmd_code_q <= 8'h00;
      params_q <= '0;
    end else begin
      cmd_valid_q <= 1'b0;
      if (wr_end && live_sel == task_file_pkg::SEL_STATUS && !soft_reset) begin
        cmd_valid_q <= 1'b1; // R04
        cmd_code_q <= s2_q.dd[7:0];
        params_q.features <= features_q; // R05
        params_q.count <= count_q;
        params_q.xfer_sectors <= count_q == 8'h00 ? task_file_pkg::SECTORS_ON_ZERO
                                                  : {1'b0, count_q}; // R24
        params_q.sector <= sector_q;
        params_q.cyl_lo <= cyl_lo_q;
        params_q.cyl_hi <= cyl_hi_q;
        params_q.unit_head <= unit_head_q; // R18
      end
    end
  end

  // An event in the acknowledge cycle survives: set beats clear
  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset) begin
      pending_q <= 1'b0;
      intrq_q <= 1'b0;
    end else begin
      if (intr_event) begin
        pending_q <= 1'b1;
      end else if (rd_end && rd_sel_q == task_file_pkg::SEL_STATUS) begin
        pending_q <= 1'b0; // R22
      end
      intrq_q <= pending_q && !ctl_q[task_file_pkg::CTL_INT_MASK] && unit_selected; // R13
    end
  end

  assign dd_out = dd_out_q;
  assign dd_oe = dd_oe_q;
  assign intrq = intrq_q;
  assign cmd_valid = cmd_valid_q;
  assign cmd_code = cmd_code_q;
  assign params = params_q;
  assign core_reset = core_reset_q;

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  soft_reset_hold_a: assert property (soft_reset |=> core_reset_q [*1] ##0 !cmd_valid_q) // R11
    else $error("core not held in reset");
  status_ack_a: assert property ((rd_end && rd_sel_q == task_file_pkg::SEL_STATUS
    && !intr_event && !soft_reset) |=> !pending_q ##1 !intrq_q) // R22
    else $error("status read did not clear interrupt");
  alt_keeps_a: assert property ((rd_end && rd_sel_q == task_file_pkg::SEL_ALT && pending_q
    && !soft_reset) |=> pending_q) // R03
    else $error("alternate status cleared interrupt");
  cmd_launch_a: assert property ((wr_end && live_sel == task_file_pkg::SEL_STATUS && !soft_reset)
    |=> cmd_valid_q && cmd_code_q == $past(s2_q.dd[7:0])) // R04
    else $error("command not launched");
  irq_gate_a: assert property (intrq_q |-> $past(!ctl_q[task_file_pkg::CTL_INT_MASK])
    && $past(pending_q)) // R13
    else $error("interrupt passed while masked");
  top_bit_a: assert property (rd_start && live_sel == task_file_pkg::SEL_DRV_ADDR
    |=> !dd_oe_q[7] && dd_oe_q[6:0] == 7'h7F) // R14
    else $error("readback bit 7 driven");
  data_gate_a: assert property (rd_start && live_sel == task_file_pkg::SEL_DATA && !xfer_req
    |=> dd_out_q == 16'h0000) // R10
    else $error("data shown without request flag");
  fixed_bits_a: assert property (rd_start && live_sel == task_file_pkg::SEL_UNIT_HEAD
    |=> dd_out_q[7] && dd_out_q[5]) // R21
    else $error("unit/head fixed bits not one");
  zero_count_a: assert property (cmd_valid_q && params_q.count == 8'h00
    |-> params_q.xfer_sectors == 9'h100) // R24
    else $error("zero count not 256");
  end_update_a: assert property (end_valid && !wr_end && !soft_reset
    |=> cyl_hi_q == $past(end_data.cyl_hi) && sector_q == $past(end_data.sector)) // R06
    else $error("command end update lost");
  unmapped_a: assert property (rd_start && live_sel == task_file_pkg::SEL_NONE
    |=> dd_oe_q == 16'h0000 [*2]) // R02
    else $error("unmapped address driven");

  launch_c: cover property (cmd_valid_q);
  irq_ack_c: cover property (intrq_q ##[1:50] (rd_end && rd_sel_q == task_file_pkg::SEL_STATUS));
  host_pop_c: cover property (host_pop ##[1:40] host_pop);
  buffer_full_c: cover property (!host_in_ready && xfer_active && !xfer_to_host);

endmodule

`default_nettype wire

// file: pkg/task_file_pkg.sv
package task_file_pkg;

  // Command block addresses (chip select 0 asserted)
  localparam logic [2:0] DA_DATA = 3'h0;
  localparam logic [2:0] DA_FEATURES = 3'h1;
  localparam logic [2:0] DA_COUNT = 3'h2;
  localparam logic [2:0] DA_SECTOR = 3'h3;
  localparam logic [2:0] DA_CYL_LO = 3'h4;
  localparam logic [2:0] DA_CYL_HI = 3'h5;
  localparam logic [2:0] DA_UNIT_HEAD = 3'h6;
  localparam logic [2:0] DA_STATUS = 3'h7;
  // Control block addresses (chip select 1 asserted)
  localparam logic [2:0] DA_ALT = 3'h6;
  localparam logic [2:0] DA_DRV_ADDR = 3'h7;

  // Port control fields
  localparam int CTL_SOFT_RESET = 2;
  localparam int CTL_INT_MASK = 1;
  localparam logic [7:0] CTL_RESET = 8'h08;

  // Unit/head fields
  localparam int UH_LBA = 6;
  localparam int UH_UNIT = 4;
  localparam logic [7:0] UH_FIXED = 8'hA0;

  // Status field carrying the transfer request flag
  localparam int ST_XFER_REQ = 3;

  // Values after reset
  localparam logic [7:0] COUNT_RESET = 8'h01;
  localparam logic [7:0] SECTOR_RESET = 8'h01;
  localparam logic [7:0] CYL_RESET = 8'h00;
  localparam logic [7:0] FEATURES_RESET = 8'h00;
  localparam logic [8:0] SECTORS_ON_ZERO = 9'h100;

  // Lanes driven per kind of read
  localparam logic [15:0] OE_WORD = 16'hFFFF;
  localparam logic [15:0] OE_BYTE = 16'h00FF;
  localparam logic [15:0] OE_DRV_ADDR = 16'h007F;
  localparam logic [15:0] OE_NONE = 16'h0000;

  // Least soft reset pulse the host gives
  localparam int SOFT_RESET_MIN_NS = 5000;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int SOFT_RESET_MIN_CYCLES =
    (SOFT_RESET_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef enum logic [3:0] {
    SEL_DATA = 4'h0,
    SEL_FEATURES = 4'h1,
    SEL_COUNT = 4'h2,
    SEL_SECTOR = 4'h3,
    SEL_CYL_LO = 4'h4,
    SEL_CYL_HI = 4'h5,
    SEL_UNIT_HEAD = 4'h6,
    SEL_STATUS = 4'h7,
    SEL_ALT = 4'h8,
    SEL_DRV_ADDR = 4'h9,
    SEL_NONE = 4'hF
  } reg_sel_t;

  typedef struct packed {
    logic cs0_n;
    logic cs1_n;
    logic [2:0] da;
    logic dior_n;
    logic diow_n;
    logic [15:0] dd;
  } pins_t;

  typedef struct packed {
    logic [7:0] features;
    logic [7:0] count;
    logic [8:0] xfer_sectors;
    logic [7:0] sector;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] unit_head;
  } taskfile_t;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] sector;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [3:0] head;
  } end_update_t;

endpackage

// file: testbench/host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input wire logic clock,
  output logic cs0_n,
  output logic cs1_n,
  output logic [2:0] da,
  output logic dior_n,
  output logic diow_n,
  output logic [15:0] dd_in,
  input wire logic [15:0] dd_out,
  input wire logic [15:0] dd_oe,
  output logic rd_done,
  output logic [31:0] rd_word
);
  logic [15:0] hd;
  logic host_oe;

  // Released lanes show the inverse of the last value, so a stale copy never passes
  assign dd_in = (dd_oe & dd_out) | (~dd_oe & (host_oe ? hd : ~hd));

  initial begin
    {cs0_n, cs1_n, dior_n, diow_n} = 4'hF;
    da = 3'h0;
    hd = 16'h0000;
    host_oe = 1'b0;
    rd_done = 1'b0;
    rd_word = 32'h0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Pins pass two sync flops, so strobes stay low six clocks and high seven before chip select drops
  task automatic access(input logic [1:0] cs_n, input logic [2:0] a, input logic wr,
                        input logic [15:0] d);
    {cs0_n, cs1_n} = cs_n;
    da = a;
    hd = d;
    host_oe = wr;
    wait_clk(1);
    if (wr) diow_n = 1'b0;
    if (!wr) dior_n = 1'b0;
    wait_clk(6);
    rd_word = {dd_oe, dd_out & dd_oe};
    rd_done = !wr;
    dior_n = 1'b1;
    diow_n = 1'b1;
    wait_clk(1);
    rd_done = 1'b0;
    wait_clk(6);
    {cs0_n, cs1_n} = 2'b11;
    host_oe = 1'b0;
    wait_clk(1);
  endtask
endmodule

`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clock, reset_n, cs0_n, cs1_n, dior_n, diow_n, intrq, intr_event, write_active;
  logic xfer_active, xfer_to_host, ecc_byte_mode, end_valid, rd_valid, rd_ready, wr_valid;
  logic wr_ready, cmd_valid, core_reset, rd_done;
  logic [2:0] da;
  logic [7:0] status_in, error_in, cmd_code;
  logic [15:0] dd_in, dd_out, dd_oe, rd_data, wr_data;
  logic [31:0] rd_word;
  task_file_pkg::end_update_t end_data;
  task_file_pkg::taskfile_t params;
  logic [63:0] rq[$];
  logic [63:0] cq[$];
  logic [15:0] wq[$];
  logic [63:0] cv;
  logic [31:0] seed = 32'h0000453E;
  int error_cnt = 0;
  int checked = 0;

  task_file_port #(.UNIT_ID(1'b0)) i_dut (.clock, .reset_n, .cs0_n, .cs1_n, .da, .dior_n,
    .diow_n, .dd_in, .dd_out, .dd_oe, .intrq, .status_in, .error_in, .intr_event,
    .write_active, .xfer_active, .xfer_to_host, .ecc_byte_mode, .end_valid, .end_data,
    .rd_valid, .rd_ready, .rd_data, .wr_valid, .wr_ready, .wr_data, .cmd_valid, .cmd_code,
    .params, .core_reset);
  host_model i_host (.clock, .cs0_n, .cs1_n, .da, .dior_n, .diow_n, .dd_in, .dd_out, .dd_oe,
    .rd_done, .rd_word);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] b(input logic [7:0] v);
    return {task_file_pkg::OE_BYTE, 8'h00, v};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic rd(input logic [1:0] cs, input logic [2:0] a, input logic [31:0] e);
    rq.push_back({32'h0, e});
    i_host.access(cs, a, 1'b0, 16'h0000);
  endtask

  task automatic wr(input logic [1:0] cs, input logic [2:0] a, input logic [15:0] d);
    i_host.access(cs, a, 1'b1, d);
  endtask

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Sampled on the falling edge so registered outputs have settled
  always @(negedge clock) begin
    if (rd_done) begin
      check("read_value", {32'h0, rd_word}, rq.pop_front());
    end
    if (cmd_valid) begin
      check("command", {7'h00, cmd_code, params.features, params.xfer_sectors,
            params.sector, params.cyl_lo, params.cyl_hi, params.unit_head}, cq.pop_front());
    end
    if (wr_valid && wr_ready) begin
      check("write_word", {48'h0, wr_data}, {48'h0, wq.pop_front()});
    end
  end

  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end

  initial begin
    logic [7:0] v[7];
    logic [15:0] w[2];
    logic [31:0] r;
    reset_n = 1'b0;
    {intr_event, write_active, xfer_active, xfer_to_host, ecc_byte_mode} = 5'h00;
    {end_valid, rd_valid, wr_ready} = 3'h0;
    end_data = '0;
    rd_data = 16'h0000;
    status_in = 8'h00;
    error_in = 8'h00;
    repeat (20) @(posedge clock);
    #1;
    reset_n = 1'b1;
    r = rnd();
    status_in = r[7:0] & 8'hF7;
    error_in = r[15:8];
    for (int i = 2; i < 7; i++) begin
      rd(2'b01, i[2:0], b(i == 6 ? 8'hA0 : (i < 4 ? 8'h01 : 8'h00)));
    end
    rd(2'b01, 3'h1, b(error_in));
    rd(2'b10, 3'h6, b(status_in));
    rd(2'b10, 3'h7, {16'h007F, 16'h007E});
    for (int i = 0; i < 6; i++) begin
      rd(2'b10, i[2:0], 32'h0);
    end
    rd(2'b11, 3'h0, 32'h0);
    rd(2'b00, 3'h7, 32'h0);
    $display("test decode done");
    for (int p = 0; p < 2; p++) begin
      for (int i = 1; i < 7; i++) begin
        r = rnd();
        v[i] = r[7:0];
      end
      if (p == 1) v[2] = 8'h00;
      v[6] = v[6] | 8'hA0;
      for (int i = 1; i < 7; i++) begin
        wr(2'b01, i[2:0], {8'h00, v[i]});
      end
      for (int i = 2; i < 7; i++) begin
        rd(2'b01, i[2:0], b(v[i]));
      end
      write_active = p[0];
      rd(2'b10, 3'h7, {16'h007F, 9'h000, ~p[0], ~v[6][3:0], ~v[6][4], v[6][4]});
      r = rnd();
      cv = {7'h00, r[7:0], v[1], v[2] == 8'h00 ? 9'h100 : {1'b0, v[2]}, v[3], v[4], v[5], v[6]};
      cq.push_back(cv);
      wr(2'b01, 3'h7, {8'h00, r[7:0]});
    end
    write_active = 1'b0;
    $display("test command done");
    r = rnd();
    end_data = {r, v[1][3:0]};
    end_valid = 1'b1;
    tick(1);
    end_valid = 1'b0;
    rd(2'b01, 3'h2, b(end_data.count));
    rd(2'b01, 3'h3, b(end_data.sector));
    rd(2'b01, 3'h4, b(end_data.cyl_lo));
    rd(2'b01, 3'h5, b(end_data.cyl_hi));
    rd(2'b01, 3'h6, b({v[6][7:4], end_data.head}));
    $display("test end_update done");
    wr(2'b01, 3'h6, 16'h00A0);
    for (int m = 0; m < 3; m++) begin
      wr(2'b10, 3'h6, m == 1 ? 16'h000A : 16'h0008);
      if (m == 2) wr(2'b01, 3'h6, 16'h00B0);
      intr_event = 1'b1;
      tick(1);
      intr_event = 1'b0;
      tick(3);
      check("intrq", {63'h0, intrq}, {63'h0, m == 0});
      rd(2'b10, 3'h6, b(status_in));
      check("intrq_alt", {63'h0, intrq}, {63'h0, m == 0});
      rd(2'b01, 3'h7, b(status_in));
      check("intrq_ack", {63'h0, intrq}, 64'h0);
    end
    $display("test interrupt done");
    wr(2'b10, 3'h6, 16'h000C);
    check("core_reset", {63'h0, core_reset}, 64'h1);
    wr(2'b01, 3'h7, 16'h0020);
    rd(2'b01, 3'h2, b(8'h01));
    tick(task_file_pkg::SOFT_RESET_MIN_CYCLES);
    wr(2'b10, 3'h6, 16'h0008);
    check("core_reset", {63'h0, core_reset}, 64'h0);
    rd(2'b01, 3'h6, b(8'hA0));
    $display("test soft_reset done");
    xfer_active = 1'b1;
    xfer_to_host = 1'b1;
    rd_valid = 1'b1;
    for (int k = 0; k < 2; k++) begin
      r = rnd();
      w[k] = r[15:0];
      rd_data = w[k];
      tick(1);
    end
    rd_valid = 1'b0;
    check("read_full", {63'h0, rd_ready}, 64'h0);
    rd(2'b01, 3'h7, b(status_in | 8'h08));
    rd(2'b01, 3'h0, {16'hFFFF, w[0]});
    ecc_byte_mode = 1'b1;
    rd(2'b01, 3'h0, b(w[1][7:0]));
    ecc_byte_mode = 1'b0;
    rd(2'b01, 3'h0, {16'hFFFF, 16'h0000});
    rd(2'b01, 3'h7, b(status_in));
    // Core side stalls so the third host word meets a full buffer
    xfer_to_host = 1'b0;
    for (int k = 0; k < 3; k++) begin
      r = rnd();
      if (k < 2) wq.push_back(r[15:0]);
      wr(2'b01, 3'h0, r[15:0]);
    end
    rd(2'b01, 3'h7, b(status_in));
    wr_ready = 1'b1;
    tick(4);
    rd(2'b01, 3'h7, b(status_in | 8'h08));
    xfer_active = 1'b0;
    check("queued", 64'(rq.size() + cq.size() + wq.size()), 64'h0);
    $display("test data_port done");
    complete_run();
  end
endmodule

`default_nettype wire
